// >>> common/dswp_pkg.sv
package dswp_pkg;
   // frame layout
   localparam int WORD_W = 16;
   localparam int CODE_W = 14;
   localparam int CTRL_HI_POS = 15;
   localparam int CTRL_LO_POS = 14;
   localparam int CODE_TOP_POS = 13;
   // control codes carried in the two top bits
   localparam logic [1:0] CTRL_LOAD = 2'h0;
   localparam logic [1:0] CTRL_RISE = 2'h3;
   // bit counting
   localparam int CNT_W = 5;
   localparam logic [4:0] BITS_PER_FRAME = 5'h10;
   localparam logic [4:0] CNT_FIRST = 5'h01;
   localparam logic [4:0] CNT_STEP = 5'h01;
   // values after reset
   localparam logic [4:0] CNT_RESET = 5'h00;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam logic [13:0] CODE_RESET = 14'h0000;
   localparam int SYNC_STAGES = 2;
   localparam int FIFO_DEPTH = 2;
   // core state, one-hot
   typedef enum logic [2:0] {
      ST_READY = 3'b001,
      ST_FRAME = 3'b010,
      ST_HALT = 3'b100
   } dswp_state_t;
endpackage : dswp_pkg

// >>> rtl/dswp_sync.sv
module dswp_sync
   import dswp_pkg::*;
#(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;

   // two-stage level synchroniser; the first stage feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= INIT;
         sync_reg <= INIT;
      end else begin
         meta_reg <= d;
         sync_reg <= meta_reg;
      end
   end

   assign q = sync_reg;
endmodule : dswp_sync

// >>> rtl/dswp_fifo2.sv
module dswp_fifo2
   import dswp_pkg::*;
#(
   parameter int W = 14
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   logic [W-1:0] mem_reg [FIFO_DEPTH];
   logic wr_ptr_reg;
   logic rd_ptr_reg;
   logic [1:0] count_reg;
   logic [1:0] count_next;
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;

   // honest full/empty from the occupancy count
   assign in_ready = (count_reg != 2'h2);
   assign out_valid = (count_reg != 2'h0);
   assign out_data = mem_reg[rd_ptr_reg];
   assign count_next = 2'(count_reg + {1'b0, push} - {1'b0, pop});

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         count_reg <= 2'h0;
      end else begin
         wr_ptr_reg <= wr_ptr_reg ^ push;
         rd_ptr_reg <= rd_ptr_reg ^ pop;
         count_reg <= count_next;
      end
   end

   // storage needs no reset, it is only read while valid
   always_ff @(posedge clk) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data;
      end
   end
endmodule : dswp_fifo2

// >>> rtl/dswp_top.sv
// Function
// - by default each data bit is captured on the falling serial clock edge.
// - frame sync is frame marker and port enable; no data accepted while high.
// - word arrives most significant bit first; host reverses order if needed.
// - output updates when frame sync ends the transfer, not per clock edge.
// - while framed, previous shift contents leave on data out at rising edges.
// - sixteen-bit word, two control bits on top, then the MSB-aligned code.
// - code 00 loads, 11 selects rising capture, others reserved; halt until next frame.
// - after the sixteenth falling edge the frame rises and the word is transferred.
// - power-up clears shift register and latches: zero code, falling capture.
module dswp_top
   import dswp_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic serial_clock_in,
   input wire logic frame_sync_n,
   input wire logic serial_data_in,
   output logic serial_data_out,
   output logic [CODE_W-1:0] conv_code,
   output logic conv_valid,
   input wire logic conv_ready,
   output logic [CODE_W-1:0] dac_code,
   output logic rise_edge_mode,
   output logic core_inoperative,
   output logic overrun
);
   ////////////////////////////////////////////////////////////////////////////////
   // reset release
   logic rst_meta_reg;
   logic rst_sync_reg;
   wire rst_sync_n = rst_sync_reg;

   // asserts at once, releases through two flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // link domain, clocked by serial_clock_in
   logic [WORD_W-1:0] neg_shift_reg;
   logic [WORD_W-1:0] neg_shift_next;
   logic [WORD_W-1:0] pos_shift_reg;
   logic [WORD_W-1:0] pos_shift_next;
   logic [CNT_W-1:0] neg_cnt_reg;
   logic [CNT_W-1:0] neg_cnt_next;
   logic [CNT_W-1:0] pos_cnt_reg;
   logic [CNT_W-1:0] pos_cnt_next;
   logic neg_act_reg;
   logic pos_act_reg;
   logic sdo_reg;
   wire link_rst_n = rst_sync_n;
   // activity flags drop with the frame so each frame restarts its count
   wire act_clr_n = link_rst_n & ~frame_sync_n;
   wire framed = ~frame_sync_n;

   // msb first: new bit enters at the bottom and walks up
   assign neg_shift_next = {neg_shift_reg[WORD_W-2:0], serial_data_in};
   assign pos_shift_next = {pos_shift_reg[WORD_W-2:0], serial_data_in};
   // saturate so over-long frames still count as complete
   assign neg_cnt_next = !neg_act_reg ? CNT_FIRST :
                         (neg_cnt_reg == BITS_PER_FRAME) ? BITS_PER_FRAME :
                         CNT_W'(neg_cnt_reg + CNT_STEP);
   assign pos_cnt_next = !pos_act_reg ? CNT_FIRST :
                         (pos_cnt_reg == BITS_PER_FRAME) ? BITS_PER_FRAME :
                         CNT_W'(pos_cnt_reg + CNT_STEP);

   // falling-edge capture path, the default
   always_ff @(negedge serial_clock_in or negedge link_rst_n) begin
      if (!link_rst_n) begin
         neg_shift_reg <= WORD_RESET;
         neg_cnt_reg <= CNT_RESET;
      end else if (framed) begin
         neg_shift_reg <= neg_shift_next;
         neg_cnt_reg <= neg_cnt_next;
      end
   end

   always_ff @(negedge serial_clock_in or negedge act_clr_n) begin
      if (!act_clr_n) begin
         neg_act_reg <= 1'b0;
      end else begin
         neg_act_reg <= 1'b1;
      end
   end

   // rising-edge capture path, used once the edge has been switched
   always_ff @(posedge serial_clock_in or negedge link_rst_n) begin
      if (!link_rst_n) begin
         pos_shift_reg <= WORD_RESET;
         pos_cnt_reg <= CNT_RESET;
      end else if (framed) begin
         pos_shift_reg <= pos_shift_next;
         pos_cnt_reg <= pos_cnt_next;
      end
   end

   always_ff @(posedge serial_clock_in or negedge act_clr_n) begin
      if (!act_clr_n) begin
         pos_act_reg <= 1'b0;
      end else begin
         pos_act_reg <= 1'b1;
      end
   end

   // readback: the top bit still holds the old word's next bit at each rise
   always_ff @(posedge serial_clock_in or negedge link_rst_n) begin
      if (!link_rst_n) begin
         sdo_reg <= 1'b0;
      end else if (framed) begin
         sdo_reg <= neg_shift_reg[WORD_W-1];
      end
   end

   assign serial_data_out = sdo_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // crossing: the frame line is synchronised, words are read only after
   // the synchronised frame end, when the link clock has stopped shifting
   logic frame_n_s;
   logic frame_n_d_reg;

   dswp_sync #(
      .W(1),
      .INIT(1'b1)
   ) u_frame_sync (
      .clk(clk),
      .rst_n(rst_sync_n),
      .d(frame_sync_n),
      .q(frame_n_s)
   );

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         frame_n_d_reg <= 1'b1;
      end else begin
         frame_n_d_reg <= frame_n_s;
      end
   end

   wire frame_end = frame_n_s & ~frame_n_d_reg;
   wire frame_start = ~frame_n_s & frame_n_d_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // core: decode the finished word
   dswp_state_t state_reg;
   dswp_state_t state_next;
   logic rise_mode_reg;
   logic pend_reg;
   logic [CODE_W-1:0] pend_code_reg;
   logic overrun_reg;
   logic [CODE_W-1:0] dac_code_reg;
   logic fifo_in_ready;

   wire [WORD_W-1:0] word_sel = rise_mode_reg ? pos_shift_reg : neg_shift_reg;
   wire [CNT_W-1:0] cnt_sel = rise_mode_reg ? pos_cnt_reg : neg_cnt_reg;
   // short frames are dropped whole; narrower cores just ignore low code bits
   wire word_ok = (cnt_sel == BITS_PER_FRAME);
   wire [1:0] ctrl_code = {word_sel[CTRL_HI_POS], word_sel[CTRL_LO_POS]};
   wire ctrl_bit_hi = ctrl_code[1];
   wire ctrl_bit_lo = ctrl_code[0];
   wire word_done = frame_end & (state_reg == ST_FRAME) & word_ok;
   wire load_ev = word_done & ~ctrl_bit_hi & ~ctrl_bit_lo;
   wire rise_ev = word_done & ctrl_bit_hi & ctrl_bit_lo;
   wire push = pend_reg & fifo_in_ready;
   wire lost_ev = load_ev & pend_reg & ~fifo_in_ready;

   // halt lasts until the next frame starts
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_READY: begin
            if (frame_start) begin
               state_next = ST_FRAME;
            end
         end
         ST_FRAME: begin
            if (rise_ev) begin
               state_next = ST_HALT;
            end else if (frame_end) begin
               state_next = ST_READY;
            end
         end
         ST_HALT: begin
            if (frame_start) begin
               state_next = ST_FRAME;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state_reg <= ST_READY;
         rise_mode_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         rise_mode_reg <= rise_mode_reg | rise_ev; // only a reset undoes it
      end
   end

   // update only on the frame's end, held until the buffer takes it
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         pend_reg <= 1'b0;
         pend_code_reg <= CODE_RESET;
      end else if (load_ev) begin
         pend_reg <= 1'b1;
         pend_code_reg <= word_sel[CODE_TOP_POS:0];
      end else if (push) begin
         pend_reg <= 1'b0;
      end
   end

   // sticky: a word arrived while the previous one still waited
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         overrun_reg <= 1'b0;
      end else begin
         overrun_reg <= overrun_reg | lost_ev;
      end
   end

   dswp_fifo2 #(
      .W(CODE_W)
   ) u_conv_fifo (
      .clk(clk),
      .rst_n(rst_sync_n),
      .in_valid(pend_reg),
      .in_ready(fifo_in_ready),
      .in_data(pend_code_reg),
      .out_valid(conv_valid),
      .out_ready(conv_ready),
      .out_data(conv_code)
   );

   // converter register follows each word the converter takes from the buffer
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         dac_code_reg <= CODE_RESET;
      end else if (conv_valid & conv_ready) begin
         dac_code_reg <= conv_code;
      end
   end

   assign dac_code = dac_code_reg;
   assign rise_edge_mode = rise_mode_reg;
   assign core_inoperative = (state_reg == ST_HALT);
   assign overrun = overrun_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_sync_n);

   a_neg_capture: assert property (@(negedge serial_clock_in) disable iff (!link_rst_n)
      !frame_sync_n |=> neg_shift_reg[0] == $past(serial_data_in))
      else $error("falling edge did not capture data bit");
   a_idle_no_data: assert property (@(negedge serial_clock_in) disable iff (!link_rst_n)
      frame_sync_n |=> $stable(neg_shift_reg))
      else $error("data accepted while frame sync high");
   a_readback_bit: assert property (@(posedge serial_clock_in) disable iff (!link_rst_n)
      !frame_sync_n |=> serial_data_out == $past(neg_shift_reg[WORD_W-1]))
      else $error("readback bit wrong");
   a_update_on_end: assert property ($rose(pend_reg) |-> $past(frame_end))
      else $error("update without frame end");
   a_load_word: assert property (load_ev |=> pend_reg && pend_code_reg == $past(word_sel[CODE_TOP_POS:0]))
      else $error("loaded code differs from shifted word");
   a_edge_switch: assert property (rise_ev |=> rise_mode_reg && core_inoperative)
      else $error("edge switch not applied");
   a_reserved_ignored: assert property (frame_end && (ctrl_code == 2'h1 || ctrl_code == 2'h2)
      |=> !$rose(pend_reg) && $stable(rise_mode_reg))
      else $error("reserved code had an effect");
   a_short_dropped: assert property (frame_end && !word_ok |=> !$rose(pend_reg) && $stable(rise_mode_reg))
      else $error("short frame was acted on");
   a_halt_holds: assert property (core_inoperative && !frame_start |=> core_inoperative)
      else $error("halt left before next frame");
   a_reset_zero: assert property (@(posedge clk) $rose(rst_sync_n) |-> dac_code == CODE_RESET
      && !rise_mode_reg && !pend_reg)
      else $error("state after reset not cleared");
   a_dac_follows: assert property (conv_valid && conv_ready |=> dac_code == $past(conv_code))
      else $error("converter register missed update");

   c_load: cover property (load_ev ##[1:20] (conv_valid && conv_ready));
   c_edge_switch: cover property (rise_ev ##[1:1000] frame_start);
   c_overrun: cover property ($rose(overrun_reg));
   c_fifo_full: cover property (pend_reg && !fifo_in_ready);
endmodule : dswp_top

// >>> testbench/dswp_host_model.sv
// host side of the serial link: clock idles low, frame low while sending
module dswp_host_model (
   output logic serial_clock_in,
   output logic frame_sync_n,
   output logic serial_data_in,
   input wire logic serial_data_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] rb;

   initial begin
      serial_clock_in = 1'b0;
      frame_sync_n = 1'b1;
      serial_data_in = 1'b0;
      rb = 16'h0000;
   end

   ////////////////////////////////////////////////////////////////////////////
   // one frame: msb first, optional pause after the first byte, optional held frame
   task automatic send(input logic [15:0] w, input int n, input bit split, input bit rise, input bit keep);
      #37 frame_sync_n = 1'b0;
      #80;
      for (int i = 0; i < n; i++) begin
         // rising mode: data moves mid low phase, clear of the falling edge the default path still uses
         #60 if (rise) serial_data_in = w[15-i];
         #20 serial_clock_in = 1'b1;
         if (!rise) serial_data_in = w[15-i];
         #80 serial_clock_in = 1'b0;
         rb = {rb[14:0], serial_data_out};
         if (split && i == 7) #400;
      end
      if (!keep) release_frame();
   endtask : send

   // frame rises after the last falling edge; data line no longer holds its value
   task automatic release_frame();
      #80 frame_sync_n = 1'b1;
      serial_data_in = ~serial_data_in;
      #300;
   endtask : release_frame

   // clocking with the frame inactive, a deliberate misuse
   task automatic noise();
      repeat (16) begin
         serial_data_in = ~serial_data_in;
         #80 serial_clock_in = 1'b1;
         #80 serial_clock_in = 1'b0;
      end
      #300;
   endtask : noise
endmodule : dswp_host_model

// >>> testbench/tb_top.sv
module tb_top;
   import dswp_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic conv_ready = 1'b0;
   logic serial_clock_in;
   logic frame_sync_n;
   logic serial_data_in;
   logic serial_data_out;
   logic [CODE_W-1:0] conv_code;
   logic conv_valid;
   logic [CODE_W-1:0] dac_code;
   logic rise_edge_mode;
   logic core_inoperative;
   logic overrun;
   int err_total = 0;
   int checked = 0;
   int cycles = 0;

   always #5 clk = ~clk;

   dswp_top dut (.clk(clk), .rst_n(rst_n), .serial_clock_in(serial_clock_in), .frame_sync_n(frame_sync_n),
      .serial_data_in(serial_data_in), .serial_data_out(serial_data_out), .conv_code(conv_code),
      .conv_valid(conv_valid), .conv_ready(conv_ready), .dac_code(dac_code), .rise_edge_mode(rise_edge_mode),
      .core_inoperative(core_inoperative), .overrun(overrun));

   dswp_host_model host (.serial_clock_in(serial_clock_in), .frame_sync_n(frame_sync_n),
      .serial_data_in(serial_data_in), .serial_data_out(serial_data_out));

   ////////////////////////////////////////////////////////////////////////////
   // comparison and closing
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic report_and_stop();
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : report_and_stop

   // crossing takes a few clocks after the frame ends; settle well past it
   task automatic settle();
      repeat (10) @(posedge clk);
      #1;
   endtask : settle

   // hang guard, about five times the expected run
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         report_and_stop();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset();
      #1;
      chk({2'h0, dac_code}, 16'h0000);
      chk({15'h0, rise_edge_mode}, 16'h0000);
      chk({15'h0, serial_data_out}, 16'h0000);
      chk({15'h0, conv_valid}, 16'h0000);
   endtask : t_reset

   // frame held low after sixteen bits must not update the output yet
   task automatic t_load();
      @(posedge clk) conv_ready <= 1'b1;
      host.send(16'h2abc, 16, 1'b0, 1'b0, 1'b1);
      settle();
      chk({2'h0, dac_code}, 16'h0000);
      host.release_frame();
      settle();
      chk({2'h0, dac_code}, 16'h2abc);
   endtask : t_load

   // two bytes in one frame, readback of the previous word
   task automatic t_bytes();
      host.send(16'h1234, 16, 1'b1, 1'b0, 1'b0);
      settle();
      chk(host.rb, 16'h2abc);
      chk({2'h0, dac_code}, 16'h1234);
   endtask : t_bytes

   // short frame and clocking while disabled are both ignored
   task automatic t_ignored();
      host.send(16'h3fff, 8, 1'b0, 1'b0, 1'b0);
      host.noise();
      settle();
      chk({2'h0, dac_code}, 16'h1234);
      chk({15'h0, conv_valid}, 16'h0000);
   endtask : t_ignored

   // reserved control codes do not load
   task automatic t_reserved();
      for (int c = 1; c < 3; c++) begin
         host.send({c[1:0], 14'h0555}, 16, 1'b0, 1'b0, 1'b0);
         settle();
         chk({2'h0, dac_code}, 16'h1234);
      end
   endtask : t_reserved

   // converter stalls: two words buffered, the waiting third is replaced by the fourth, then drained in order
   task automatic t_stall();
      logic [13:0] exp [3];
      exp = '{14'h0011, 14'h0022, 14'h0033};
      @(posedge clk) conv_ready <= 1'b0;
      for (int k = 0; k < 3; k++)
         host.send({2'h0, exp[k]}, 16, 1'b0, 1'b0, 1'b0);
      settle();
      chk({15'h0, overrun}, 16'h0000);
      host.send(16'h0044, 16, 1'b0, 1'b0, 1'b0);
      settle();
      chk({15'h0, overrun}, 16'h0001);
      // the newest word overwrites the one left pending, so the output tracks the last frame
      exp[2] = 14'h0044;
      for (int k = 0; k < 3; k++) begin
         chk({15'h0, conv_valid}, 16'h0001);
         chk({2'h0, conv_code}, {2'h0, exp[k]});
         @(posedge clk) conv_ready <= 1'b1;
         @(posedge clk) conv_ready <= 1'b0;
         repeat (3) @(posedge clk);
         #1;
         chk({2'h0, dac_code}, {2'h0, exp[k]});
      end
      chk({15'h0, conv_valid}, 16'h0000);
      @(posedge clk) conv_ready <= 1'b1;
   endtask : t_stall

   // code 11 moves capture to the rising edge; the next frame loads normally
   task automatic t_edge();
      host.send(16'hc000, 16, 1'b0, 1'b0, 1'b0);
      settle();
      chk({15'h0, rise_edge_mode}, 16'h0001);
      chk({15'h0, core_inoperative}, 16'h0001);
      chk({2'h0, dac_code}, 16'h0044);
      host.send(16'h0abc, 16, 1'b0, 1'b1, 1'b0);
      settle();
      chk({15'h0, core_inoperative}, 16'h0000);
      chk({2'h0, dac_code}, 16'h0abc);
   endtask : t_edge

   initial begin
      repeat (6) @(posedge clk);
      t_reset();
      @(posedge clk) rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      t_load();
      t_bytes();
      t_ignored();
      t_reserved();
      t_stall();
      t_edge();
      report_and_stop();
   end
endmodule : tb_top
